// >>> core/alert_overheat_pkg.sv
/*
 * Constants for the alert masking and overheat timer block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock.
 */
package alert_overheat_pkg;

    // register offsets
    localparam logic [7:0] STATUS_ONE_ADDR     = 8'h41;
    localparam logic [7:0] STATUS_TWO_ADDR     = 8'h42;
    localparam logic [7:0] ALERT_MASK_ONE_ADDR = 8'h74;
    localparam logic [7:0] ALERT_MASK_TWO_ADDR = 8'h75;
    localparam logic [7:0] CONFIG_THREE_ADDR   = 8'h78;
    localparam logic [7:0] OVERHEAT_TIMER_ADDR = 8'h79;
    localparam logic [7:0] OVERHEAT_LIMIT_ADDR = 8'h7A;
    localparam logic [7:0] CONFIG_FOUR_ADDR    = 8'h7D;

    // reset values
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET  = 8'h00;

    // implemented source bits; unused ones read zero, status one bit7 reads the summary
    localparam logic [7:0] STATUS_ONE_USED = 8'h75;
    localparam logic [7:0] STATUS_TWO_USED = 8'hFE;

    // field positions
    localparam int SUMMARY_BIT       = 7;
    localparam int OVERHEAT_FLAG_BIT = 5;
    localparam int ALERT_A_EN_BIT    = 0;
    localparam int OVERHEAT_EN_BIT   = 1;
    localparam int FULL_SPEED_BIT    = 2;
    localparam int ALERT_B_EN_BIT    = 0;

    // timer
    localparam logic [7:0] TIMER_FULL     = 8'hFF;
    localparam logic [7:0] TIMER_FIRST    = 8'h01;
    localparam logic [7:0] TIMER_ZERO     = 8'h00;
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         TIMER_STEP_NS  = 22_760_000;
    localparam int         STEP_CYCLES    = TIMER_STEP_NS / CLK_PERIOD_NS;
    localparam int         NUM_FANS       = 3;

endpackage

// >>> core/alert_overheat.sv
/*
 * Alert masking, alert pin enables, sticky status and overheat input timer.
 * Assumes an external serial engine turns bus transfers into single-cycle
 * register read and write strobes, and that limit comparison and fan drive
 * live outside and report through level inputs.
 */
module alert_overheat #(
    parameter int STEP_CYCLES = alert_overheat_pkg::STEP_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // out-of-limit sources, level high while out of limit
    input  wire logic [7:0]  status_one_src_i,
    input  wire logic [7:0]  status_two_src_i,
    // overheat pin, active low, asynchronous
    input  wire logic        overheat_pin_n_i,
    // fan state and override
    input  wire logic [2:0]  fan_running_i,
    output logic      [2:0]  full_speed_override_o,
    // open-drain alert pins, enable high pulls the pin low
    output logic             alert_a_o,
    output logic             alert_a_oe_o,
    output logic             alert_on_alt_pin_b_o,
    output logic             alert_on_alt_pin_b_oe_o
);

    localparam logic [17:0] STEP_LAST = 18'(STEP_CYCLES - 1);

    logic        rst_meta_r;
    logic        rst_n_r;
    logic        pin_meta_r;
    logic        pin_sync_n_r;

    logic [7:0]  mask_one_r,  mask_one_nxt;
    logic [7:0]  mask_two_r,  mask_two_nxt;
    logic [7:0]  cfg_three_r, cfg_three_nxt;
    logic [7:0]  cfg_four_r,  cfg_four_nxt;
    logic [7:0]  limit_r,     limit_nxt;
    logic [7:0]  stat_one_r,  stat_one_nxt;
    logic [7:0]  stat_two_r,  stat_two_nxt;
    logic [7:0]  steps_r,     steps_nxt;
    logic        seen_r,      seen_nxt;
    logic [17:0] presc_r,     presc_nxt;
    logic [7:0]  rdata_r,     rdata_nxt;
    logic        alert_a_r,   alert_a_nxt;
    logic        alert_b_r,   alert_b_nxt;
    logic [2:0]  full_r,      full_nxt;

    logic        overheat_en;
    logic        asserted;
    logic [7:0]  timer_val;
    logic        limit_hit;
    logic [7:0]  src_two;
    logic        rd_timer;
    logic        rd_one;
    logic        rd_two;
    logic        pending;

    // reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // pin synchroniser; idle high so no false assertion out of reset
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_meta_r   <= 1'b1;
            pin_sync_n_r <= 1'b1;
        end else begin
            pin_meta_r   <= overheat_pin_n_i;
            pin_sync_n_r <= pin_meta_r;
        end
    end

    assign overheat_en = cfg_three_r[alert_overheat_pkg::OVERHEAT_EN_BIT];
    assign asserted    = overheat_en && !pin_sync_n_r;

    // value shows one until two full steps have passed
    assign timer_val = (steps_r >= 8'h02) ? steps_r
                     : (seen_r ? alert_overheat_pkg::TIMER_FIRST
                               : alert_overheat_pkg::TIMER_ZERO);

    // restart at one re-flags zero limit
    // strictly above the limit; zero trips on first assertion
    assign limit_hit = overheat_en && (timer_val > limit_r);

    // bit5 source swaps to the overheat flag when pin is ours
    always_comb begin
        src_two = status_two_src_i & alert_overheat_pkg::STATUS_TWO_USED;
        if (overheat_en) begin
            src_two[alert_overheat_pkg::OVERHEAT_FLAG_BIT] = limit_hit;
        end
    end

    assign rd_timer = reg_rd_i && (reg_addr_i == alert_overheat_pkg::OVERHEAT_TIMER_ADDR);
    assign rd_one   = reg_rd_i && (reg_addr_i == alert_overheat_pkg::STATUS_ONE_ADDR);
    assign rd_two   = reg_rd_i && (reg_addr_i == alert_overheat_pkg::STATUS_TWO_ADDR);

    // per-source gating, mask one bit7 covers all of status two
    assign pending = (|(stat_one_r & ~mask_one_r & alert_overheat_pkg::STATUS_ONE_USED
                        & 8'h7F))
                   || (!mask_one_r[alert_overheat_pkg::SUMMARY_BIT]
                        && |(stat_two_r & ~mask_two_r));

    // configuration writes
    always_comb begin
        mask_one_nxt  = mask_one_r;
        mask_two_nxt  = mask_two_r;
        cfg_three_nxt = cfg_three_r;
        cfg_four_nxt  = cfg_four_r;
        limit_nxt     = limit_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                alert_overheat_pkg::ALERT_MASK_ONE_ADDR: mask_one_nxt  = reg_wdata_i;
                alert_overheat_pkg::ALERT_MASK_TWO_ADDR: mask_two_nxt  = reg_wdata_i;
                alert_overheat_pkg::CONFIG_THREE_ADDR:   cfg_three_nxt = reg_wdata_i;
                alert_overheat_pkg::CONFIG_FOUR_ADDR:    cfg_four_nxt  = reg_wdata_i;
                alert_overheat_pkg::OVERHEAT_LIMIT_ADDR: limit_nxt     = reg_wdata_i;
                default: ;
            endcase
        end
    end

    // sticky status and timer
    always_comb begin
        logic [7:0] src_one;
        src_one = status_one_src_i & alert_overheat_pkg::STATUS_ONE_USED;
        // read clears only bits whose cause is gone; set wins
        stat_two_nxt = (rd_two ? (stat_two_r & src_two) : stat_two_r) | src_two;
        stat_one_nxt = (rd_one ? (stat_one_r & src_one) : stat_one_r) | src_one;
        stat_one_nxt[alert_overheat_pkg::SUMMARY_BIT] = |stat_two_nxt;

        steps_nxt = steps_r;
        seen_nxt  = seen_r;
        presc_nxt = presc_r;
        if (rd_timer) begin
            // clear on read; restart at one if still asserted
            steps_nxt = alert_overheat_pkg::TIMER_ZERO;
            presc_nxt = 18'h00000;
            seen_nxt  = asserted;
        end else if (asserted) begin
            // count only while asserted, hold otherwise
            seen_nxt = 1'b1;
            if (presc_r >= STEP_LAST) begin
                presc_nxt = 18'h00000;
                if (steps_r != alert_overheat_pkg::TIMER_FULL) begin
                    steps_nxt = steps_r + 8'h01;
                end
            end else begin
                presc_nxt = presc_r + 18'h00001;
            end
        end
    end

    // read data, outputs
    always_comb begin
        case (reg_addr_i)
            alert_overheat_pkg::STATUS_ONE_ADDR:     rdata_nxt = stat_one_r;
            alert_overheat_pkg::STATUS_TWO_ADDR:     rdata_nxt = stat_two_r;
            alert_overheat_pkg::ALERT_MASK_ONE_ADDR: rdata_nxt = mask_one_r;
            alert_overheat_pkg::ALERT_MASK_TWO_ADDR: rdata_nxt = mask_two_r;
            alert_overheat_pkg::CONFIG_THREE_ADDR:   rdata_nxt = cfg_three_r;
            alert_overheat_pkg::OVERHEAT_TIMER_ADDR: rdata_nxt = timer_val;
            alert_overheat_pkg::OVERHEAT_LIMIT_ADDR: rdata_nxt = limit_r;
            alert_overheat_pkg::CONFIG_FOUR_ADDR:    rdata_nxt = cfg_four_r;
            default:                                 rdata_nxt = 8'h00;
        endcase
        if (!reg_rd_i) begin
            rdata_nxt = rdata_r;
        end
        // pin pulls low only when enabled and pending
        alert_a_nxt = pending && cfg_three_r[alert_overheat_pkg::ALERT_A_EN_BIT];
        alert_b_nxt = pending && cfg_four_r[alert_overheat_pkg::ALERT_B_EN_BIT];
        // override only on running fans with bit set
        full_nxt = (cfg_three_r[alert_overheat_pkg::FULL_SPEED_BIT] && asserted)
                 ? fan_running_i : 3'h0;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mask_one_r  <= alert_overheat_pkg::MASK_RESET;
            mask_two_r  <= alert_overheat_pkg::MASK_RESET;
            cfg_three_r <= alert_overheat_pkg::CONFIG_RESET;
            cfg_four_r  <= alert_overheat_pkg::CONFIG_RESET;
            limit_r     <= alert_overheat_pkg::LIMIT_RESET;
            stat_one_r  <= 8'h00;
            stat_two_r  <= 8'h00;
            steps_r     <= alert_overheat_pkg::TIMER_ZERO;
            seen_r      <= 1'b0;
            presc_r     <= 18'h00000;
            rdata_r     <= 8'h00;
            alert_a_r   <= 1'b0;
            alert_b_r   <= 1'b0;
            full_r      <= 3'h0;
        end else begin
            mask_one_r  <= mask_one_nxt;
            mask_two_r  <= mask_two_nxt;
            cfg_three_r <= cfg_three_nxt;
            cfg_four_r  <= cfg_four_nxt;
            limit_r     <= limit_nxt;
            stat_one_r  <= stat_one_nxt;
            stat_two_r  <= stat_two_nxt;
            steps_r     <= steps_nxt;
            seen_r      <= seen_nxt;
            presc_r     <= presc_nxt;
            rdata_r     <= rdata_nxt;
            alert_a_r   <= alert_a_nxt;
            alert_b_r   <= alert_b_nxt;
            full_r      <= full_nxt;
        end
    end

    assign reg_rdata_o             = rdata_r;
    assign alert_a_o               = 1'b0;
    assign alert_on_alt_pin_b_o    = 1'b0;
    assign alert_a_oe_o            = alert_a_r;
    assign alert_on_alt_pin_b_oe_o = alert_b_r;
    assign full_speed_override_o   = full_r;

    a_mask_keeps_status: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (status_one_src_i[4] && mask_one_r[4]) |=> stat_one_r[4])
        else $error("masked source did not set status");

    a_alert_disabled: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        !cfg_three_r[0] |=> !alert_a_oe_o)
        else $error("alert pin a driven while disabled");

    a_alert_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (cfg_four_r[0] && stat_one_r[2] && !mask_one_r[2]) |=> alert_on_alt_pin_b_oe_o)
        else $error("unmasked status did not drive alert pin b");

    a_override_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        !cfg_three_r[2] |=> (full_speed_override_o == 3'h0))
        else $error("override active with bit cleared");

    a_override_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (!fan_running_i[0] || pin_sync_n_r) |=> !full_speed_override_o[0])
        else $error("override on stopped fan or idle pin");

    a_timer_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (!asserted && !rd_timer) |=> ($stable(steps_r) && $stable(seen_r)))
        else $error("timer moved while pin idle");

    a_timer_saturate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (steps_r == 8'hFF && !rd_timer) |=> (steps_r == 8'hFF))
        else $error("timer left full scale without read");

    a_read_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (rd_timer && asserted) |=> (seen_r && steps_r == 8'h00 && timer_val == 8'h01))
        else $error("read during assertion did not restart at one");

    a_zero_reflag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (rd_timer && asserted && limit_r == 8'h00) |-> ##2 stat_two_r[5])
        else $error("read during assertion with zero limit did not re-flag");

    a_limit_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        limit_hit |=> stat_two_r[5] ##1 (stat_one_r[7]))
        else $error("limit exceed did not flag status");

    a_sticky_status: assert property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (stat_two_r[7] && !rd_two) |=> stat_two_r[7])
        else $error("status bit dropped without read");

endmodule // alert_overheat

// >>> sim/hot_source.sv
/*
 * Model of the processor hot signal on the overheat pin.
 * Assumes the bench calls drive() from its main sequence; the pin idles high.
 */
module hot_source (
    // clock
    input  wire logic sys_clk_i,
    // active-low pin drive
    output logic      overheat_pin_n_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial overheat_pin_n_o = 1'b1;

    task automatic drive(input logic lvl);
        @(posedge sys_clk_i);
        overheat_pin_n_o <= lvl;
    endtask
endmodule // hot_source

// >>> sim/testbench.sv
/*
 * Self-checking bench for the alert and overheat timer block.
 * Assumes the block sees single-cycle register strobes; STEP_CYCLES is 4.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] S1 = alert_overheat_pkg::STATUS_ONE_ADDR;
    localparam logic [7:0] S2 = alert_overheat_pkg::STATUS_TWO_ADDR;
    localparam logic [7:0] M1 = alert_overheat_pkg::ALERT_MASK_ONE_ADDR;
    localparam logic [7:0] M2 = alert_overheat_pkg::ALERT_MASK_TWO_ADDR;
    localparam logic [7:0] C3 = alert_overheat_pkg::CONFIG_THREE_ADDR;
    localparam logic [7:0] TM = alert_overheat_pkg::OVERHEAT_TIMER_ADDR;
    localparam logic [7:0] LM = alert_overheat_pkg::OVERHEAT_LIMIT_ADDR;
    localparam logic [7:0] C4 = alert_overheat_pkg::CONFIG_FOUR_ADDR;

    logic       clk;
    logic       rstn;
    logic [7:0] addr;
    logic       wr_s;
    logic       rd_s;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] s1_src;
    logic [7:0] s2_src;
    logic       pin_n;
    logic [2:0] fan;
    logic [2:0] ovr;
    logic       a_o;
    logic       a_oe;
    logic       b_o;
    logic       b_oe;
    logic [7:0] regs [6];
    int         errors;
    int         checks;
    int         cyc;

    alert_overheat #(.STEP_CYCLES(4)) u_alert_overheat (
        .sys_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .status_one_src_i(s1_src), .status_two_src_i(s2_src),
        .overheat_pin_n_i(pin_n), .fan_running_i(fan), .full_speed_override_o(ovr),
        .alert_a_o(a_o), .alert_a_oe_o(a_oe), .alert_on_alt_pin_b_o(b_o),
        .alert_on_alt_pin_b_oe_o(b_oe));

    hot_source u_hot_source (.sys_clk_i(clk), .overheat_pin_n_o(pin_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk("reg_rdata_o", e, rdata);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // run limit well above the ~1260 cycles of the sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        rstn = 1'b0; addr = 8'h00; wr_s = 1'b0; rd_s = 1'b0; wdata = 8'h00;
        s1_src = 8'h00; s2_src = 8'h00; fan = 3'b101;
        regs = '{M1, M2, C3, TM, LM, C4};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        wt(4);
        chk("alert_oe", 8'h00, {a_oe, b_oe});
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(8'h50, 8'h00);
        wr(M1, 8'hA5);
        rd(M1, 8'hA5);
        wr(M1, 8'h00);
        wr(C4, 8'h01);
        wr(C3, 8'h01);
        @(posedge clk) s1_src <= 8'h40;
        @(posedge clk) s1_src <= 8'h00;
        wt(2);
        chk("alert_oe", 8'h03, {a_oe, b_oe});
        wr(M1, 8'h40);
        wt(2);
        chk("alert_oe", 8'h00, {a_oe, b_oe});
        rd(S1, 8'h40);
        rd(S1, 8'h00);
        @(posedge clk) s2_src <= 8'h02;
        @(posedge clk) s2_src <= 8'h00;
        wt(2);
        chk("alert_oe", 8'h03, {a_oe, b_oe});
        wr(M1, 8'h80);
        wt(2);
        chk("alert_oe", 8'h00, {a_oe, b_oe});
        wr(M1, 8'h00);
        wr(M2, 8'h02);
        wt(2);
        chk("alert_oe", 8'h00, {a_oe, b_oe});
        rd(S1, 8'h80);
        rd(S2, 8'h02);
        rd(S2, 8'h00);
        wr(M2, 8'h00);
        // every source at once; only status one bit 2 left unmasked
        wr(M1, 8'hFB);
        @(posedge clk);
        s1_src <= 8'hFF;
        s2_src <= 8'hFF;
        @(posedge clk);
        s1_src <= 8'h00;
        s2_src <= 8'h00;
        wt(2);
        chk("alert_oe", 8'h03, {a_oe, b_oe});
        chk("alert_data", 8'h00, {a_o, b_o});
        rd(S1, 8'hF5);
        rd(S2, 8'hFE);
        wt(2);
        chk("alert_oe", 8'h00, {a_oe, b_oe});
        wr(M1, 8'h00);
        // monitoring off: pin activity must not reach the timer
        u_hot_source.drive(1'b0);
        wt(6);
        u_hot_source.drive(1'b1);
        rd(TM, 8'h00);
        wr(LM, 8'h01);
        rd(LM, 8'h01);
        wr(C3, 8'h03);
        u_hot_source.drive(1'b0);
        wt(4);
        chk("override", 8'h00, ovr);
        u_hot_source.drive(1'b1);
        wt(3);
        rd(TM, 8'h01);
        u_hot_source.drive(1'b0);
        wt(4);
        u_hot_source.drive(1'b1);
        wt(3);
        chk("alert_a_oe", 8'h00, a_oe);
        u_hot_source.drive(1'b0);
        wt(4);
        u_hot_source.drive(1'b1);
        wt(3);
        chk("alert_a_oe", 8'h01, a_oe);
        wr(M2, 8'h20);
        wt(2);
        chk("alert_a_oe", 8'h00, a_oe);
        rd(TM, 8'h02);
        rd(TM, 8'h00);
        // host clears the limit flag once the timer is read
        rd(S2, 8'h20);
        rd(S2, 8'h00);
        wr(LM, 8'h00);
        wr(M2, 8'h00);
        wr(C3, 8'h07);
        u_hot_source.drive(1'b0);
        wt(4);
        chk("override", 8'h05, ovr);
        @(posedge clk) fan <= 3'b010;
        wt(2);
        chk("override", 8'h02, ovr);
        wt(1100);
        rd(TM, 8'hFF);
        rd(TM, 8'h01);
        rd(S2, 8'h20);
        u_hot_source.drive(1'b1);
        wt(4);
        chk("override", 8'h00, ovr);
        complete_run();
    end
endmodule // testbench
